// ---- design/ndc_defines.svh ----
`ifndef NDC_DEFINES_SVH
`define NDC_DEFINES_SVH

// Clock period and pin timing, in nanoseconds.
`define NDC_CLK_NS       25
`define NDC_T_PULSE_NS   50
`define NDC_T_HOLD_NS    25
`define NDC_T_WB_NS      100
// Least times round up to whole clock cycles.
`define NDC_CYC(ns)      (((ns) + `NDC_CLK_NS - 1) / `NDC_CLK_NS)
`define NDC_PULSE_CYC    `NDC_CYC(`NDC_T_PULSE_NS)
`define NDC_HOLD_CYC     `NDC_CYC(`NDC_T_HOLD_NS)
`define NDC_WB_CYC       `NDC_CYC(`NDC_T_WB_NS)

// Flash command codes.
`define NDC_C_READ       8'h00
`define NDC_C_CB_READ    8'h35
`define NDC_C_CB_IN      8'h85
`define NDC_C_CONFIRM    8'h10
`define NDC_C_ERASE      8'h60
`define NDC_C_ERASE_GO   8'hD0
`define NDC_C_STATUS     8'h70
`define NDC_C_ID         8'h90
`define NDC_C_RESET      8'hFF
`define NDC_ID_ADDR      8'h00
`define NDC_ID_BYTES     5

// Status byte reset value, mask of unused bits and bit positions.
`define NDC_STAT_RST     8'hC0
`define NDC_STAT_MASK    8'hE3
`define NDC_SB_FAIL      0
`define NDC_SB_TRUE_RDY  5
`define NDC_SB_RDY       6
`define NDC_SB_WP        7

// Register byte offsets.
`define NDC_REG_CMD      8'h00
`define NDC_REG_STAT     8'h04
`define NDC_REG_COL      8'h08
`define NDC_REG_ROW      8'h0C
`define NDC_REG_DATA     8'h10
`define NDC_REG_ID0      8'h14
`define NDC_REG_ID1      8'h18
`define NDC_REG_CFG      8'h1C

// Bits of the state register.
`define NDC_ST_BUSY      0
`define NDC_ST_REFUSED   1
`define NDC_ST_RB        2
`define NDC_ST_SMODE     3
`define NDC_ST_FAIL      4
`define NDC_ST_BYTE_LSB  8

`endif

// ---- design/ndc_pkg.sv ----
package ndc_pkg;

   // Operations that software may order.
   typedef enum logic [3:0] {
      OP_NONE       = 4'h0,
      OP_CB_READ    = 4'h1,
      OP_CB_SETUP   = 4'h2,
      OP_RAND_IN    = 4'h3,
      OP_CB_CONFIRM = 4'h4,
      OP_ERASE      = 4'h5,
      OP_STATUS     = 4'h6,
      OP_READ_ID    = 4'h7,
      OP_DREAD      = 4'h8,
      OP_RESET      = 4'h9
   } ndc_op_t;

   // Kind of one step of an operation.
   typedef enum logic [2:0] {
      K_CMD  = 3'h0,
      K_ADDR = 3'h1,
      K_WR   = 3'h2,
      K_RD   = 3'h3,
      K_WAIT = 3'h4,
      K_END  = 3'h5
   } ndc_kind_t;

   typedef struct packed {
      ndc_kind_t  kind;
      logic [7:0] data;
   } ndc_step_t;

   // Byte cycle states.
   typedef enum logic [2:0] {
      CY_IDLE = 3'b001,
      CY_LOW  = 3'b010,
      CY_HIGH = 3'b100
   } ndc_cyc_t;

   // Sequencer states.
   typedef enum logic [4:0] {
      EN_IDLE  = 5'b00001,
      EN_ISSUE = 5'b00010,
      EN_CYC   = 5'b00100,
      EN_WLO   = 5'b01000,
      EN_WHI   = 5'b10000
   } ndc_eng_t;

endpackage

// ---- design/ndc_pin_cycle.sv ----
`timescale 1ns/100ps
`include "ndc_defines.svh"

module ndc_pin_cycle
   import ndc_pkg::*;
#(
   parameter int PULSE = `NDC_PULSE_CYC,
   parameter int HOLD  = `NDC_HOLD_CYC
) (
   // Clock and reset.
   input  wire logic       clk,
   input  wire logic       rst_n,
   // One byte cycle request.
   input  wire logic       go,
   input  wire logic       rd,
   input  wire logic       cle_in,
   input  wire logic       ale_in,
   input  wire logic [7:0] byte_in,
   output logic            done,
   output logic [7:0]      rd_byte,
   // Flash pins.
   output logic            cle,
   output logic            ale,
   output logic            we_n,
   output logic            re_n,
   output logic [7:0]      io_out,
   output logic            io_oe_n,
   input  wire logic [7:0] io_in
);

   ndc_cyc_t   state, next_state;
   logic [7:0] cnt, next_cnt;
   logic       next_done, next_cle, next_ale, next_we_n, next_re_n;
   logic       next_oe_n;
   logic [7:0] next_out, next_rd_byte;

   // Strobe low for PULSE cycles, then high for HOLD cycles. The flash
   // latches on the rising write strobe, so data stays put through HOLD.
   always_comb begin
      next_state   = state;
      next_cnt     = cnt;
      next_done    = 1'b0;
      next_cle     = cle;
      next_ale     = ale;
      next_we_n    = we_n;
      next_re_n    = re_n;
      next_oe_n    = io_oe_n;
      next_out     = io_out;
      next_rd_byte = rd_byte;
      case (state)
         CY_IDLE: begin
            if (go) begin
               next_cle   = cle_in;
               next_ale   = ale_in;
               next_out   = byte_in;
               next_oe_n  = rd;
               next_we_n  = rd;
               next_re_n  = ~rd;
               next_cnt   = 8'(PULSE - 1);
               next_state = CY_LOW;
            end
         end
         CY_LOW: begin
            if (cnt == 8'h00) begin
               next_we_n  = 1'b1;
               next_re_n  = 1'b1;
               next_cnt   = 8'(HOLD - 1);
               next_state = CY_HIGH;
               if (!re_n) begin
                  next_rd_byte = io_in; // Sampled at the end of the pulse.
               end
            end else begin
               next_cnt = cnt - 8'h01;
            end
         end
         CY_HIGH: begin
            if (cnt == 8'h00) begin
               next_done  = 1'b1;
               next_oe_n  = 1'b1;
               next_cle   = 1'b0;
               next_ale   = 1'b0;
               next_state = CY_IDLE;
            end else begin
               next_cnt = cnt - 8'h01;
            end
         end
         default: begin
            next_state = CY_IDLE;
         end
      endcase
   end

   // Registers of the byte cycle; every pin comes from a flip-flop.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state   <= CY_IDLE;
         cnt     <= 8'h00;
         done    <= 1'b0;
         cle     <= 1'b0;
         ale     <= 1'b0;
         we_n    <= 1'b1;
         re_n    <= 1'b1;
         io_oe_n <= 1'b1;
         io_out  <= 8'h00;
         rd_byte <= 8'h00;
      end else begin
         state   <= next_state;
         cnt     <= next_cnt;
         done    <= next_done;
         cle     <= next_cle;
         ale     <= next_ale;
         we_n    <= next_we_n;
         re_n    <= next_re_n;
         io_oe_n <= next_oe_n;
         io_out  <= next_out;
         rd_byte <= next_rd_byte;
      end
   end

endmodule // ndc_pin_cycle

// ---- design/ndc_host.sv ----
`timescale 1ns/100ps
`include "ndc_defines.svh"

module ndc_host
   import ndc_pkg::*;
#(
   parameter int PLANE_BIT = 6
) (
   // Clock and reset.
   input  wire logic        MCLK,
   input  wire logic        RST_N,
   // Wishbone slave.
   input  wire logic        WB_CYC,
   input  wire logic        WB_STB,
   input  wire logic        WB_WE,
   input  wire logic [7:0]  WB_ADR,
   input  wire logic [3:0]  WB_SEL,
   input  wire logic [31:0] WB_DAT_I,
   output logic [31:0]      WB_DAT_O,
   output logic             WB_ACK,
   // Flash pins.
   output logic             CE_N,
   output logic             CLE,
   output logic             ALE,
   output logic             WE_N,
   output logic             RE_N,
   output logic             WP_N,
   output logic [7:0]       IO_OUT,
   output logic             IO_OE_N,
   input  wire logic [7:0]  IO_IN,
   input  wire logic        RB
);

   logic        req, next_ack;
   logic [31:0] next_dat_o, rdv;
   logic [7:0]  adr;
   logic [11:0] col, next_col;
   logic [15:0] row, next_row;
   logic [7:0]  wdat, next_wdat;
   logic        next_wp_n;

   ndc_eng_t    state, next_state;
   ndc_op_t     op, next_op, new_op;
   logic [3:0]  idx, next_idx;
   logic [7:0]  wcnt, next_wcnt;
   logic [7:0]  status, next_status;
   logic [7:0]  rdata, next_rdata;
   logic [7:0]  id_b [0:`NDC_ID_BYTES-1];
   logic [7:0]  next_id_b [0:`NDC_ID_BYTES-1];
   logic [15:0] src_row, next_src_row;
   logic        refused, next_refused, smode, next_smode, next_ce_n;
   logic        go, next_go, go_rd, next_go_rd, go_cle, next_go_cle;
   logic        go_ale, next_go_ale;
   logic [7:0]  go_byte, next_go_byte;
   logic        cyc_done;
   logic [7:0]  cyc_byte;
   logic        cmd_wr, stat_wr, can_take, bad_op, bad_cb;
   ndc_step_t   st;

   // Steps of each operation, indexed by position.
   function automatic ndc_step_t step_of(input ndc_op_t o,
                                         input logic [3:0] i,
                                         input logic [11:0] c,
                                         input logic [15:0] r,
                                         input logic [7:0] d);
      ndc_step_t s;
      s = '{K_END, 8'h00};
      case (o)
         OP_CB_READ, OP_CB_SETUP: begin
            case (i)
               4'h0: s = '{K_CMD, (o == OP_CB_READ) ? `NDC_C_READ
                                                     : `NDC_C_CB_IN};
               4'h1: s = '{K_ADDR, c[7:0]};
               4'h2: s = '{K_ADDR, {4'h0, c[11:8]}};
               4'h3: s = '{K_ADDR, r[7:0]};
               4'h4: s = '{K_ADDR, r[15:8]};
               4'h5: if (o == OP_CB_READ) s = '{K_CMD, `NDC_C_CB_READ};
               4'h6: if (o == OP_CB_READ) s = '{K_WAIT, 8'h00};
               default: s = '{K_END, 8'h00};
            endcase
         end
         OP_RAND_IN: begin
            case (i)
               4'h0: s = '{K_CMD, `NDC_C_CB_IN};
               4'h1: s = '{K_ADDR, c[7:0]};
               4'h2: s = '{K_ADDR, {4'h0, c[11:8]}};
               4'h3: s = '{K_WR, d};
               default: s = '{K_END, 8'h00};
            endcase
         end
         OP_ERASE: begin
            case (i)
               4'h0: s = '{K_CMD, `NDC_C_ERASE};
               4'h1: s = '{K_ADDR, {r[7:6], 6'h00}}; // Page bits zero.
               4'h2: s = '{K_ADDR, r[15:8]};
               4'h3: s = '{K_CMD, `NDC_C_ERASE_GO};
               4'h4: s = '{K_WAIT, 8'h00};
               4'h5: s = '{K_CMD, `NDC_C_STATUS};
               4'h6: s = '{K_RD, 8'h00};
               default: s = '{K_END, 8'h00};
            endcase
         end
         OP_READ_ID: begin
            if (i == 4'h0) s = '{K_CMD, `NDC_C_ID};
            else if (i == 4'h1) s = '{K_ADDR, `NDC_ID_ADDR};
            else if (i < 4'(2 + `NDC_ID_BYTES)) s = '{K_RD, 8'h00};
         end
         OP_DREAD: begin
            if (i == 4'h0) s = '{K_CMD, `NDC_C_READ};
            else if (i == 4'h1) s = '{K_RD, 8'h00};
         end
         OP_STATUS: begin
            if (i == 4'h0) s = '{K_CMD, `NDC_C_STATUS};
            else if (i == 4'h1) s = '{K_RD, 8'h00};
         end
         OP_CB_CONFIRM, OP_RESET: begin
            case (i)
               4'h0: s = '{K_CMD, (o == OP_RESET) ? `NDC_C_RESET
                                                   : `NDC_C_CONFIRM};
               4'h1: s = '{K_WAIT, 8'h00};
               4'h2: s = '{K_CMD, `NDC_C_STATUS};
               4'h3: s = '{K_RD, 8'h00};
               default: s = '{K_END, 8'h00};
            endcase
         end
         default: s = '{K_END, 8'h00};
      endcase
      return s;
   endfunction

   // Bus decode; ack answers one cycle after the request and then drops.
   assign adr     = {WB_ADR[7:2], 2'b00};
   assign req     = WB_CYC & WB_STB & ~WB_ACK;
   assign cmd_wr  = req & WB_WE & WB_SEL[0] & (adr == `NDC_REG_CMD);
   assign stat_wr = req & WB_WE & WB_SEL[0] & (adr == `NDC_REG_STAT);

   // Read mux; unmapped offsets read as zero and are still acknowledged.
   always_comb begin
      rdv = 32'h0000_0000;
      case (adr)
         `NDC_REG_CMD:  rdv = {28'h000_0000, op};
         `NDC_REG_STAT: begin
            rdv[`NDC_ST_BUSY]    = ~state[0];
            rdv[`NDC_ST_REFUSED] = refused;
            rdv[`NDC_ST_RB]      = RB;
            rdv[`NDC_ST_SMODE]   = smode;
            rdv[`NDC_ST_FAIL]    = status[`NDC_SB_FAIL];
            rdv[`NDC_ST_BYTE_LSB +: 8] = status;
         end
         `NDC_REG_COL:  rdv = {20'h0_0000, col};
         `NDC_REG_ROW:  rdv = {16'h0000, row};
         `NDC_REG_DATA: rdv = {24'h00_0000, rdata};
         `NDC_REG_ID0:  rdv = {id_b[3], id_b[2], id_b[1], id_b[0]};
         `NDC_REG_ID1:  rdv = {24'h00_0000, id_b[4]};
         `NDC_REG_CFG:  rdv = {31'h0000_0000, WP_N};
         default:       rdv = 32'h0000_0000;
      endcase
   end

   // Software-held registers, written lane by lane.
   always_comb begin
      next_ack   = req;
      next_dat_o = req ? rdv : WB_DAT_O;
      next_col   = col;
      next_row   = row;
      next_wdat  = wdat;
      next_wp_n  = WP_N;
      if (req && WB_WE) begin
         if (adr == `NDC_REG_COL) begin
            if (WB_SEL[0]) next_col[7:0] = WB_DAT_I[7:0];
            if (WB_SEL[1]) next_col[11:8] = WB_DAT_I[11:8];
         end
         if (adr == `NDC_REG_ROW) begin
            if (WB_SEL[0]) next_row[7:0] = WB_DAT_I[7:0];
            if (WB_SEL[1]) next_row[15:8] = WB_DAT_I[15:8];
         end
         if (adr == `NDC_REG_DATA && WB_SEL[0]) next_wdat = WB_DAT_I[7:0];
         if (adr == `NDC_REG_CFG && WB_SEL[0]) next_wp_n = WB_DAT_I[0];
      end
   end

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         WB_ACK   <= 1'b0;
         WB_DAT_O <= 32'h0000_0000;
         col      <= 12'h000;
         row      <= 16'h0000;
         wdat     <= 8'h00;
         WP_N     <= 1'b0;
      end else begin
         WB_ACK   <= next_ack;
         WB_DAT_O <= next_dat_o;
         col      <= next_col;
         row      <= next_row;
         wdat     <= next_wdat;
         WP_N     <= next_wp_n;
      end
   end

   // Order checks. While the flash is busy only reset is taken, and a
   // reset may cut into any wait, another reset's included.
   assign new_op   = ndc_op_t'(WB_DAT_I[3:0]);
   assign bad_op   = (new_op == OP_NONE) || (WB_DAT_I[3:0] > 4'h9);
   assign bad_cb   = (new_op == OP_CB_SETUP) &&
                     ((row[PLANE_BIT] != src_row[PLANE_BIT]) ||
                      (row[0] != src_row[0]));
   assign can_take = !bad_op && !bad_cb && (state == EN_IDLE ||
                     ((state == EN_WLO || state == EN_WHI) &&
                      new_op == OP_RESET));
   assign st       = step_of(op, idx, col, row, wdat);

   // Sequencer: fetch a step, run a byte cycle or wait on ready/busy.
   always_comb begin
      next_state   = state;
      next_op      = op;
      next_idx     = idx;
      next_wcnt    = wcnt;
      next_status  = status;
      next_rdata   = rdata;
      next_id_b    = id_b;
      next_src_row = src_row;
      next_smode   = smode;
      next_refused = refused;
      next_go      = 1'b0;
      next_go_rd   = go_rd;
      next_go_cle  = go_cle;
      next_go_ale  = go_ale;
      next_go_byte = go_byte;
      if (stat_wr && WB_DAT_I[`NDC_ST_REFUSED]) next_refused = 1'b0;
      case (state)
         EN_ISSUE: begin
            next_idx = idx + 4'h1;
            if (st.kind == K_WAIT) begin
               next_wcnt  = 8'(`NDC_WB_CYC);
               next_state = EN_WLO;
            end else if (st.kind == K_END) begin
               next_state = EN_IDLE;
            end else begin
               next_go      = 1'b1;
               next_go_rd   = (st.kind == K_RD);
               next_go_cle  = (st.kind == K_CMD);
               next_go_ale  = (st.kind == K_ADDR);
               next_go_byte = st.data;
               if (st.kind == K_CMD) begin
                  next_smode = (st.data == `NDC_C_STATUS);
               end
               next_state = EN_CYC;
            end
         end
         EN_CYC: begin
            if (cyc_done) begin
               next_state = EN_ISSUE;
               if (go_rd && op == OP_READ_ID) begin
                  next_id_b[3'(idx - 4'h3)] = cyc_byte;
               end else if (go_rd && op == OP_DREAD) begin
                  next_rdata = cyc_byte;
               end else if (go_rd) begin
                  // Unused bits masked; ready, true ready, write protect
                  // and pass/fail kept.
                  next_status = cyc_byte & `NDC_STAT_MASK;
               end
            end
         end
         // Give the flash its busy lead time before trusting a high RB.
         EN_WLO: begin
            if (!RB || wcnt == 8'h00) next_state = EN_WHI;
            else next_wcnt = wcnt - 8'h01;
         end
         EN_WHI: begin
            if (RB) next_state = EN_ISSUE;
         end
         default: begin
            next_state = EN_IDLE;
         end
      endcase
      if (cmd_wr) begin
         if (can_take) begin
            next_op    = new_op;
            next_state = EN_ISSUE;
            next_idx   = (new_op == OP_DREAD && !smode) ? 4'h1 : 4'h0;
            if (new_op == OP_CB_READ) next_src_row = row;
            if (new_op == OP_RESET) next_status = `NDC_STAT_RST;
         end else begin
            next_refused = 1'b1; // Set wins over a same-cycle clear.
         end
      end
   end

   assign next_ce_n = (next_state == EN_IDLE);

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         state   <= EN_IDLE;
         op      <= OP_NONE;
         idx     <= 4'h0;
         wcnt    <= 8'h00;
         status  <= `NDC_STAT_RST;
         rdata   <= 8'h00;
         id_b    <= '{default: 8'h00};
         src_row <= 16'h0000;
         smode   <= 1'b0; // Power-up acts as if 00h is latched.
         refused <= 1'b0;
         CE_N    <= 1'b1;
         go      <= 1'b0;
         go_rd   <= 1'b0;
         go_cle  <= 1'b0;
         go_ale  <= 1'b0;
         go_byte <= 8'h00;
      end else begin
         state   <= next_state;
         op      <= next_op;
         idx     <= next_idx;
         wcnt    <= next_wcnt;
         status  <= next_status;
         rdata   <= next_rdata;
         id_b    <= next_id_b;
         src_row <= next_src_row;
         smode   <= next_smode;
         refused <= next_refused;
         CE_N    <= next_ce_n;
         go      <= next_go;
         go_rd   <= next_go_rd;
         go_cle  <= next_go_cle;
         go_ale  <= next_go_ale;
         go_byte <= next_go_byte;
      end
   end

   // One byte cycle on the flash pins.
   ndc_pin_cycle u_cycle (
      .clk     (MCLK),
      .rst_n   (RST_N),
      .go      (go),
      .rd      (go_rd),
      .cle_in  (go_cle),
      .ale_in  (go_ale),
      .byte_in (go_byte),
      .done    (cyc_done),
      .rd_byte (cyc_byte),
      .cle     (CLE),
      .ale     (ALE),
      .we_n    (WE_N),
      .re_n    (RE_N),
      .io_out  (IO_OUT),
      .io_oe_n (IO_OE_N),
      .io_in   (IO_IN)
   );

endmodule // ndc_host

// ---- testbench/ndc_host_assertions.sv ----
`timescale 1ns/100ps

module ndc_host_assertions (
   // Clock and reset.
   input wire logic       MCLK,
   input wire logic       RST_N,
   // Bus handshake.
   input wire logic       WB_CYC,
   input wire logic       WB_STB,
   input wire logic       WB_ACK,
   // Flash pins.
   input wire logic       CE_N,
   input wire logic       CLE,
   input wire logic       ALE,
   input wire logic       WE_N,
   input wire logic       RE_N,
   input wire logic       IO_OE_N,
   input wire logic [7:0] IO_OUT
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RST_N);

   logic [7:0] last_cmd;
   logic [2:0] n_addr;

   // Last latched command and the address bytes sent since.
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         last_cmd <= 8'h00;
         n_addr   <= 3'h0;
      end else if ($rose(WE_N) && CLE) begin
         last_cmd <= IO_OUT;
         n_addr   <= 3'h0;
      end else if ($rose(WE_N) && ALE) begin
         n_addr <= n_addr + 3'h1;
      end
   end

   // A strobe stays low for two cycles before it rises.
   sequence s_we_pulse;
      !WE_N ##1 WE_N;
   endsequence
   sequence s_re_pulse;
      !RE_N ##1 RE_N;
   endsequence

   a_ack_next: assert property ((WB_CYC && WB_STB && !WB_ACK) |=> WB_ACK)
      else $error("ack missing");
   a_ack_single: assert property (WB_ACK |=> !WB_ACK)
      else $error("ack too long");
   a_we_width: assert property ($fell(WE_N) |=> s_we_pulse)
      else $error("write strobe width");
   a_re_width: assert property ($fell(RE_N) |=> s_re_pulse)
      else $error("read strobe width");
   a_strobe_select: assert property ((!WE_N || !RE_N) |-> !CE_N)
      else $error("strobe without select");
   a_read_release: assert property (!RE_N |-> (IO_OE_N && !CLE && !ALE))
      else $error("bus driven in read");
   a_write_drive: assert property (!WE_N |-> !IO_OE_N)
      else $error("bus not driven in write");
   a_latch_hold: assert property ($rose(WE_N) |-> $stable(IO_OUT))
      else $error("data moved at latch");
   a_erase_confirm: assert property (($rose(WE_N) && CLE &&
      IO_OUT == 8'hD0) |-> (last_cmd == 8'h60 && n_addr == 3'h2))
      else $error("erase confirm out of order");
   a_erase_addr: assert property (($rose(WE_N) && ALE &&
      last_cmd == 8'h60 && n_addr == 3'h0) |-> IO_OUT[5:0] == 6'h00)
      else $error("erase page bits not zero");
   a_copy_confirm: assert property (($rose(WE_N) && CLE &&
      IO_OUT == 8'h10) |-> last_cmd == 8'h85)
      else $error("confirm without setup");
   a_id_addr: assert property (($rose(WE_N) && ALE &&
      last_cmd == 8'h90) |-> IO_OUT == 8'h00)
      else $error("id address not zero");
endmodule // ndc_host_assertions

bind ndc_host ndc_host_assertions i_ndc_host_assertions (.MCLK, .RST_N,
   .WB_CYC, .WB_STB, .WB_ACK, .CE_N, .CLE, .ALE, .WE_N, .RE_N, .IO_OE_N,
   .IO_OUT);

// ---- testbench/ndc_flash_model.sv ----
`timescale 1ns/100ps

module ndc_flash_model #(
   parameter logic [39:0] ID = 40'h00_0000_0000
) (
   // Timing base and control pins.
   input wire logic       MCLK,
   input wire logic       CE_N,
   input wire logic       CLE,
   input wire logic       ALE,
   input wire logic       WE_N,
   input wire logic       RE_N,
   input wire logic       WP_N,
   input wire logic       fail_next,
   // Data and ready lines.
   input wire logic [7:0] IO_OUT,
   output logic [7:0]     q,
   output logic           rb
);
   int         busy  = 0;
   int         na    = 0;
   int         idx   = 0;
   int         mode  = 0; // Power-up acts as if 00h were latched.
   logic       fail  = 1'b0;
   logic       rflag = 1'b0;
   logic [11:0] col  = 12'h000;

   // Open-drain line, pulled high while idle.
   assign rb = (busy == 0);

   // Busy time runs out on the system clock.
   always @(posedge MCLK) begin
      if (busy > 0) busy--;
   end

   // Commands, addresses and data latch on the rising write strobe.
   always @(posedge WE_N) begin
      if (!CE_N && CLE && (busy == 0 || IO_OUT == 8'h70 ||
                           IO_OUT == 8'hFF)) begin
         na = 0;
         case (IO_OUT)
            8'hFF: begin
               busy  = 10;
               rflag = 1'b1;
               fail  = 1'b0;
            end
            8'h70: mode = 1;
            8'h90: begin
               mode = 2;
               idx  = 0;
            end
            8'h00: mode = 0;
            8'h35: begin
               busy = 20;
               mode = 0;
            end
            8'h10, 8'hD0: begin
               busy  = 60;
               fail  = fail_next;
               rflag = 1'b0;
            end
            default: ;
         endcase
      end else if (!CE_N && ALE) begin
         if (na == 0) col[7:0] = IO_OUT;
         if (na == 1) col[11:8] = IO_OUT[3:0];
         na++;
      end else if (!CE_N && !CLE) begin
         col++; // Data byte is not stored; only the column moves on.
      end
   end

   // Read cycles; unused bits read as ones to catch a missing mask.
   always @(negedge RE_N) begin
      if (!CE_N) begin
         case (mode)
            1: q = {WP_N, rb, rb & !rflag, 3'b111, 1'b0, fail};
            2: begin
               q = ID[8*idx +: 8];
               idx++;
            end
            default: begin
               q = col[7:0] ^ 8'hA5;
               col++;
            end
         endcase
      end
   end

   // A released bus shows the inverse so a late sample cannot pass.
   always @(posedge RE_N) q = ~q;
endmodule // ndc_flash_model

// ---- testbench/tb_ndc_host.sv ----
`timescale 1ns/100ps

module tb_ndc_host;
   localparam logic [39:0] ID = 40'h9A_7856_3412; // Arbitrary value.
   logic        MCLK = 0, RST_N = 0, WB_CYC = 0, WB_STB = 0, WB_WE = 0;
   logic        fail_next = 0;
   logic [7:0]  WB_ADR = 8'h00;
   logic [3:0]  WB_SEL = 4'hF;
   logic [31:0] WB_DAT_I = 32'h0000_0000, WB_DAT_O, q;
   logic        WB_ACK, CE_N, CLE, ALE, WE_N, RE_N, WP_N, IO_OE_N, RB;
   logic [7:0]  IO_OUT, IO_IN;
   logic [31:0] bad_row [2] = '{32'h0000_0043, 32'h0000_0002};
   int          n_mismatch = 0, samples_checked = 0, cycles = 0;

   ndc_host i_ndc_host (.MCLK, .RST_N, .WB_CYC, .WB_STB, .WB_WE, .WB_ADR,
      .WB_SEL, .WB_DAT_I, .WB_DAT_O, .WB_ACK, .CE_N, .CLE, .ALE, .WE_N,
      .RE_N, .WP_N, .IO_OUT, .IO_OE_N, .IO_IN, .RB);
   ndc_flash_model #(.ID(ID)) i_ndc_flash_model (.MCLK, .CE_N, .CLE,
      .ALE, .WE_N, .RE_N, .WP_N, .fail_next, .IO_OUT, .q(IO_IN), .rb(RB));

   // Clock and a ceiling on the run length.
   always #12.5 MCLK = ~MCLK;
   always @(posedge MCLK) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         end_of_test();
      end
   end

   task end_of_test;
      if (n_mismatch == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         n_mismatch++;
         $display("BAD %s exp %h seen %h", n, e, s);
      end
   endtask

   // Classic cycle: hold the request until ack is sampled high.
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge MCLK);
      WB_CYC   <= 1'b1;
      WB_STB   <= 1'b1;
      WB_WE    <= w;
      WB_ADR   <= a;
      WB_DAT_I <= d;
      do @(posedge MCLK); while (WB_ACK !== 1'b1);
      q = WB_DAT_O;
      WB_CYC <= 1'b0;
      WB_STB <= 1'b0;
   endtask

   task rd(input string n, input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0000_0000);
      chk(n, q, e);
   endtask

   task poll(input int b, input logic v);
      repeat (200) begin
         wb(1'b0, 8'h04, 32'h0000_0000);
         if (q[b] === v) break;
      end
   endtask

   task run(input logic [3:0] op);
      wb(1'b1, 8'h00, {28'h000_0000, op});
      poll(0, 1'b0);
   endtask

   // Main sequence of operations and expected register values.
   initial begin
      repeat (16) @(posedge MCLK);
      RST_N <= 1'b1;
      rd("stat_rst", 8'h04, 32'h0000_C004);
      rd("unmapped", 8'h20, 32'h0000_0000);
      wb(1'b1, 8'h1C, 32'h0000_0001);
      rd("cfg", 8'h1C, 32'h0000_0001);
      run(4'h6);
      rd("stat", 8'h04, 32'h0000_E00C);
      run(4'h7);
      rd("id0", 8'h14, ID[31:0]);
      rd("id1", 8'h18, {24'h00_0000, ID[39:32]});
      wb(1'b1, 8'h0C, 32'h0000_FFFF);
      fail_next <= 1'b1;
      run(4'h5);
      fail_next <= 1'b0;
      rd("erase_fail", 8'h04, 32'h0000_E11C);
      wb(1'b1, 8'h00, 32'h0000_0005);
      wb(1'b1, 8'h00, 32'h0000_0006);
      poll(2, 1'b0);
      run(4'h9);
      rd("reset", 8'h04, 32'h0000_C00E);
      wb(1'b1, 8'h04, 32'h0000_0002);
      rd("clear", 8'h04, 32'h0000_C00C);
      wb(1'b1, 8'h00, 32'h0000_000A);
      rd("bad_op", 8'h04, 32'h0000_C00E);
      rd("cmd_keep", 8'h00, 32'h0000_0009);
      wb(1'b1, 8'h04, 32'h0000_0002);
      wb(1'b1, 8'h08, 32'h0000_0010);
      wb(1'b1, 8'h0C, 32'h0000_0042);
      run(4'h1);
      run(4'h8);
      rd("cb_data0", 8'h10, 32'h0000_00B5);
      run(4'h8);
      rd("cb_data1", 8'h10, 32'h0000_00B4);
      foreach (bad_row[i]) begin
         wb(1'b1, 8'h0C, bad_row[i]);
         run(4'h2);
         wb(1'b0, 8'h04, 32'h0000_0000);
         chk("cb_refuse", q & 32'h0000_0002, 32'h0000_0002);
         wb(1'b1, 8'h04, 32'h0000_0002);
      end
      wb(1'b1, 8'h0C, 32'h0000_0044);
      rd("row", 8'h0C, 32'h0000_0044);
      run(4'h2);
      wb(1'b1, 8'h10, 32'h0000_005A);
      run(4'h3);
      run(4'h4);
      rd("cb_prog", 8'h04, 32'h0000_E00C);
      run(4'h8);
      rd("after_stat", 8'h10, 32'h0000_00B4);
      wb(1'b1, 8'h00, 32'h0000_0009);
      poll(2, 1'b0);
      run(4'h9);
      rd("reset2", 8'h04, 32'h0000_C00C);
      wb(1'b1, 8'h1C, 32'h0000_0000);
      run(4'h6);
      rd("stat_wp", 8'h04, 32'h0000_400C);
      end_of_test();
   end
endmodule // tb_ndc_host
